// ==== bab_pkg.sv ====
package bab_pkg;

	// ****************************************
	// Register map and field layout
	// ****************************************
	localparam int BAB_PADDR_W = 12;
	localparam logic [11:0] BAB_OFS_CTRL = 12'h000;
	localparam logic [11:0] BAB_OFS_STAT = 12'h004;
	localparam logic [11:0] BAB_OFS_ADDR = 12'h008;
	localparam logic [11:0] BAB_OFS_DATA = 12'h00c;
	localparam int BAB_CTRL_UNMASK = 7;
	localparam int BAB_CTRL_CSEL_HI = 6;
	localparam int BAB_CTRL_CSEL_LO = 5;
	localparam int BAB_CTRL_ACMP_HI = 4;
	localparam int BAB_CTRL_ACMP_LO = 2;
	localparam int BAB_CTRL_DCMP_HI = 1;
	localparam int BAB_CTRL_DCMP_LO = 0;
	localparam int BAB_STAT_FLAG = 7;
	localparam int BAB_STAT_IE = 6;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] BAB_CTRL_RST = 8'h80;
	localparam logic [5:0] BAB_STAT_RSV = 6'h3f;
	localparam logic [15:0] BAB_ADDR_RST = 16'hffff;

	// ****************************************
	// Condition codes
	// ****************************************
	localparam logic [1:0] BAB_CSEL_EXEC = 2'h0;
	localparam logic [1:0] BAB_CSEL_READ = 2'h1;
	localparam logic [1:0] BAB_CSEL_WRITE = 2'h2;
	localparam logic [1:0] BAB_CSEL_RDWR = 2'h3;
	localparam logic [2:0] BAB_ACMP_16 = 3'h0;
	localparam logic [2:0] BAB_ACMP_12 = 3'h1;
	localparam logic [2:0] BAB_ACMP_8 = 3'h2;
	localparam logic [2:0] BAB_ACMP_4 = 3'h3;
	localparam logic [1:0] BAB_DCMP_NONE = 2'h0;
	localparam logic [1:0] BAB_DCMP_LOW = 2'h1;
	localparam logic [1:0] BAB_DCMP_HIGH = 2'h2;
	localparam logic [1:0] BAB_DCMP_WORD = 2'h3;

	// CPU bus cycle kinds
	localparam logic [1:0] BAB_KIND_FETCH = 2'h0;
	localparam logic [1:0] BAB_KIND_READ = 2'h1;
	localparam logic [1:0] BAB_KIND_WRITE = 2'h2;

	// One CPU bus cycle as seen by the comparator
	typedef struct packed {
		logic valid;
		logic [1:0] kind;
		logic is_word;
		logic io8;
		logic [15:0] addr;
		logic [15:0] data;
	} bab_cpu_bus_t;

	// Mask of address bits that take part in the compare
	function automatic logic [15:0] bab_addr_mask(input logic [2:0] acmp);
		case (acmp)
			BAB_ACMP_16: bab_addr_mask = 16'hffff;
			BAB_ACMP_12: bab_addr_mask = 16'hfff0;
			BAB_ACMP_8: bab_addr_mask = 16'hff00;
			BAB_ACMP_4: bab_addr_mask = 16'hf000;
			default: bab_addr_mask = 16'h0000;
		endcase
	endfunction

endpackage

// ==== bab_addr_cmp.sv ====
`timescale 1ns/10ps
module bab_addr_cmp import bab_pkg::*; (
	input wire logic [15:0] brk_addr_i,
	input wire logic [15:0] bus_addr_i,
	input wire logic [2:0] acmp_i,
	output logic match_o
);

	// Reserved widths never match
	logic reserved;
	logic [15:0] mask;
	assign reserved = acmp_i[2];
	assign mask = bab_addr_mask(acmp_i);
	assign match_o = !reserved && (((brk_addr_i ^ bus_addr_i) & mask) == 16'h0000);

endmodule

// ==== bab_data_cmp.sv ====
`timescale 1ns/10ps
module bab_data_cmp import bab_pkg::*; (
	input wire logic [15:0] brk_data_i,
	input wire bab_cpu_bus_t bus_i,
	input wire logic [1:0] dcmp_i,
	output logic match_o
);

	// Lane validity per access size and address
	logic wide_word;
	logic hi_valid;
	logic lo_valid;
	logic hi_eq;
	logic lo_eq;
	assign wide_word = bus_i.is_word && !bus_i.io8;
	assign hi_valid = !(wide_word && bus_i.addr[0]);
	assign lo_valid = wide_word;
	assign hi_eq = hi_valid && (bus_i.data[15:8] == brk_data_i[15:8]);
	assign lo_eq = lo_valid && (bus_i.data[7:0] == brk_data_i[7:0]);

	// Data qualification select
	assign match_o = (dcmp_i == BAB_DCMP_NONE) ||
		((dcmp_i == BAB_DCMP_LOW) && lo_eq) ||
		((dcmp_i == BAB_DCMP_HIGH) && hi_eq) ||
		((dcmp_i == BAB_DCMP_WORD) && hi_eq && lo_eq);

endmodule

// ==== bab_top.sv ====
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
module bab_top import bab_pkg::*; (
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [BAB_PADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire bab_cpu_bus_t BUS_I,
	input wire logic RTE_DONE_I,
	input wire logic INSTR_DONE_I,
	output logic IRQ_O,
	output logic RTE_HOLD_O
);

	// ****************************************
	// Storage
	// ****************************************
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic flag_reg;
	logic flag_next;
	logic ie_reg;
	logic ie_next;
	logic armed_reg;
	logic armed_next;
	logic [15:0] addr_reg;
	logic [15:0] addr_next;
	logic [15:0] data_reg;
	logic [15:0] data_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;

	// Return-hold state
	typedef enum logic {BAB_RUN, BAB_HOLD} bab_hold_t;
	bab_hold_t hold_reg;
	bab_hold_t hold_next;

	// ****************************************
	// Field views
	// ****************************************
	logic unmask;
	logic [1:0] csel;
	logic [2:0] acmp;
	logic [1:0] dcmp;
	assign unmask = ctrl_reg[BAB_CTRL_UNMASK];
	assign csel = ctrl_reg[BAB_CTRL_CSEL_HI:BAB_CTRL_CSEL_LO];
	assign acmp = ctrl_reg[BAB_CTRL_ACMP_HI:BAB_CTRL_ACMP_LO];
	assign dcmp = ctrl_reg[BAB_CTRL_DCMP_HI:BAB_CTRL_DCMP_LO];

	// ****************************************
	// APB decode
	// ****************************************
	logic setup;
	logic access;
	logic sel_ctrl;
	logic sel_stat;
	logic sel_addr;
	logic sel_data;
	logic mapped;
	logic wr;
	logic rd_setup;
	logic rd_access;

	// Address decode and phase qualifiers
	assign setup = PSEL_I && !PENABLE_I;
	assign access = PSEL_I && PENABLE_I;
	assign sel_ctrl = (PADDR_I == BAB_OFS_CTRL);
	assign sel_stat = (PADDR_I == BAB_OFS_STAT);
	assign sel_addr = (PADDR_I == BAB_OFS_ADDR);
	assign sel_data = (PADDR_I == BAB_OFS_DATA);
	assign mapped = sel_ctrl || sel_stat || sel_addr || sel_data;
	assign wr = access && PWRITE_I && mapped;
	assign rd_setup = setup && !PWRITE_I;
	assign rd_access = access && !PWRITE_I;

	// Zero wait states, error on unmapped address
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = access && !mapped;
	assign PRDATA_O = prdata_reg;

	// ****************************************
	// Break detection
	// ****************************************
	logic addr_hit;
	logic data_hit;
	logic kind_hit;
	logic break_hit;

	bab_addr_cmp u_addr_cmp (
		.brk_addr_i(addr_reg),
		.bus_addr_i(BUS_I.addr),
		.acmp_i(acmp),
		.match_o(addr_hit)
	);

	bab_data_cmp u_data_cmp (
		.brk_data_i(data_reg),
		.bus_i(BUS_I),
		.dcmp_i(dcmp),
		.match_o(data_hit)
	);

	// Cycle type qualification
	assign kind_hit = ((csel == BAB_CSEL_EXEC) && (BUS_I.kind == BAB_KIND_FETCH)) ||
		((csel == BAB_CSEL_READ) && (BUS_I.kind == BAB_KIND_READ)) ||
		((csel == BAB_CSEL_WRITE) && (BUS_I.kind == BAB_KIND_WRITE)) ||
		((csel == BAB_CSEL_RDWR) && ((BUS_I.kind == BAB_KIND_READ) ||
		(BUS_I.kind == BAB_KIND_WRITE)));
	assign break_hit = BUS_I.valid && kind_hit && addr_hit && data_hit;

	// ****************************************
	// Flag clear handshake
	// ****************************************
	logic stat_wr;
	logic clear_ok;
	logic stat_rd_set;

	// Zero write after a read that saw the flag set
	assign stat_wr = wr && sel_stat && PSTRB_I[0];
	assign clear_ok = stat_wr && !PWDATA_I[BAB_STAT_FLAG] && armed_reg;
	assign stat_rd_set = rd_access && sel_stat && flag_reg;

	// Flag, set wins over clear
	assign flag_next = break_hit ? 1'b1 : (clear_ok ? 1'b0 : flag_reg);
	assign armed_next = stat_rd_set ? 1'b1 : (stat_wr ? 1'b0 : armed_reg);
	assign ie_next = stat_wr ? PWDATA_I[BAB_STAT_IE] : ie_reg;

	// ****************************************
	// Register writes
	// ****************************************
	assign ctrl_next = (wr && sel_ctrl && PSTRB_I[0]) ? PWDATA_I[7:0] : ctrl_reg;
	assign addr_next[7:0] = (wr && sel_addr && PSTRB_I[0]) ? PWDATA_I[7:0] : addr_reg[7:0];
	assign addr_next[15:8] = (wr && sel_addr && PSTRB_I[1]) ? PWDATA_I[15:8] : addr_reg[15:8];
	assign data_next[7:0] = (wr && sel_data && PSTRB_I[0]) ? PWDATA_I[7:0] : data_reg[7:0];
	assign data_next[15:8] = (wr && sel_data && PSTRB_I[1]) ? PWDATA_I[15:8] : data_reg[15:8];

	// Read mux, captured in setup phase
	always_comb begin
		prdata_next = prdata_reg;
		if (rd_setup) begin
			if (sel_ctrl) begin
				prdata_next = {24'h000000, ctrl_reg};
			end else if (sel_stat) begin
				prdata_next = {24'h000000, flag_reg, ie_reg, BAB_STAT_RSV};
			end else if (sel_addr) begin
				prdata_next = {16'h0000, addr_reg};
			end else if (sel_data) begin
				prdata_next = {16'h0000, data_reg};
			end else begin
				prdata_next = 32'h00000000;
			end
		end
	end

	// ****************************************
	// Return hold sequencing
	// ****************************************
	always_comb begin
		hold_next = hold_reg;
		case (hold_reg)
			BAB_RUN: begin
				if (RTE_DONE_I && !unmask) begin
					hold_next = BAB_HOLD;
				end
			end
			BAB_HOLD: begin
				if (INSTR_DONE_I) begin
					hold_next = BAB_RUN;
				end
			end
			default: hold_next = BAB_RUN;
		endcase
	end

	// Hold applies only while the unmask bit is clear
	assign RTE_HOLD_O = (hold_reg == BAB_HOLD) && !unmask;

	// Request not gated by any CPU mask bit
	assign IRQ_O = flag_reg && ie_reg;

	// ****************************************
	// Flip-flops
	// ****************************************
	// Control state with reset
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ctrl_reg <= BAB_CTRL_RST;
			flag_reg <= 1'b0;
			ie_reg <= 1'b0;
			armed_reg <= 1'b0;
			addr_reg <= BAB_ADDR_RST;
			prdata_reg <= 32'h00000000;
			hold_reg <= BAB_RUN;
		end else begin
			ctrl_reg <= ctrl_next;
			flag_reg <= flag_next;
			ie_reg <= ie_next;
			armed_reg <= armed_next;
			addr_reg <= addr_next;
			prdata_reg <= prdata_next;
			hold_reg <= hold_next;
		end
	end

	// Break data, no reset value
	always_ff @(posedge CLK_I) begin
		data_reg <= data_next;
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking bab_cb @(posedge CLK_I);
	endclocking
	default disable iff (!ARST_N_I);

	a_match_sets_flag: assert property (break_hit |=> flag_reg)
		else $error("break match did not set flag");

	a_flag_stays_set: assert property (flag_reg && !clear_ok |=> flag_reg)
		else $error("break flag dropped without clear");

	a_clear_needs_read: assert property (flag_reg && stat_wr && !armed_reg |=> flag_reg)
		else $error("flag cleared without prior read");

	a_clear_after_read: assert property (clear_ok && !break_hit |=> !flag_reg)
		else $error("flag not cleared after read and zero write");

	a_irq_needs_enable: assert property (!ie_reg |-> !IRQ_O)
		else $error("request without enable");

	a_irq_both_set: assert property (break_hit && ie_reg && !stat_wr |=> IRQ_O)
		else $error("request missing after enabled break");

	a_status_rsv_ones: assert property (rd_setup && sel_stat |=> PRDATA_O[5:0] == 6'h3f)
		else $error("status reserved bits not one");

	a_exec_only_fetch: assert property (
		break_hit && (csel == BAB_CSEL_EXEC) |-> BUS_I.kind == BAB_KIND_FETCH)
		else $error("execution break on non-fetch cycle");

	a_reserved_no_hit: assert property (acmp[2] |-> !break_hit)
		else $error("break with reserved address width");

	a_byte_upper_lane: assert property (
		break_hit && (dcmp == BAB_DCMP_LOW) |-> BUS_I.is_word && !BUS_I.io8)
		else $error("lower lane matched on byte access");

	a_hold_after_return: assert property (
		RTE_DONE_I && !unmask && (hold_reg == BAB_RUN) |=> RTE_HOLD_O || unmask)
		else $error("no hold after return");

	a_unmask_no_hold: assert property (unmask |-> !RTE_HOLD_O)
		else $error("hold while unmask set");

	a_addr_write_lanes: assert property (
		wr && sel_addr && PSTRB_I[1] && !PSTRB_I[0] |=> addr_reg[7:0] == $past(addr_reg[7:0]))
		else $error("low address byte changed on high-half write");

	a_apb_read_data: assert property (
		rd_setup && sel_ctrl ##1 rd_access |-> PRDATA_O[7:0] == $past(ctrl_reg))
		else $error("control read data wrong");

endmodule

// ==== bab_cpu_model.sv ====
`timescale 1ns/10ps
module bab_cpu_model import bab_pkg::*; (
	input wire logic clk_i,
	output bab_cpu_bus_t bus_o,
	output logic rte_done_o,
	output logic instr_done_o
);
	// ****************************************
	// CPU side of the comparator
	// ****************************************
	// Idle bus at time zero
	initial begin
		bus_o = '0;
		rte_done_o = 1'b0;
		instr_done_o = 1'b0;
	end

	// One bus cycle, byte and narrow I/O data on the upper lane
	task automatic cycle(input logic [1:0] kind, input logic word, input logic io8, input logic [15:0] addr,
		input logic [15:0] data);
		@(posedge clk_i);
		bus_o <= {1'b1, kind, word, io8, addr, data};
		@(posedge clk_i);
		bus_o.valid <= 1'b0;
		bus_o.data <= ~data; // Released lane shows no stale value
	endtask

	// One-cycle completion pulse, return or instruction
	task automatic pulse(input logic instr);
		@(posedge clk_i);
		rte_done_o <= ~instr;
		instr_done_o <= instr;
		@(posedge clk_i);
		rte_done_o <= 1'b0;
		instr_done_o <= 1'b0;
	endtask
endmodule

// ==== tb_bab_top.sv ====
`timescale 1ns/10ps
module tb_bab_top import bab_pkg::*;;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, hold, return_from_exception_instr, instr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	bab_cpu_bus_t bus;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;

	bab_top u_bab_top(.CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'h3), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .BUS_I(bus), .RTE_DONE_I(return_from_exception_instr), .INSTR_DONE_I(instr), .IRQ_O(irq), .RTE_HOLD_O(hold));
	bab_cpu_model u_bab_cpu_model(.clk_i(clk), .bus_o(bus), .rte_done_o(return_from_exception_instr), .instr_done_o(instr));

	// Clock generator
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			errors++;
			$display("unexpected at %0t: timeout", $time);
			results;
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic results;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// APB transfer, held until pready is seen
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic err);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			errors++;
			$display("unexpected at %0t: no ready", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp, msg);
	endtask

	// Program, run one bus cycle, judge, then clear the flag
	task automatic brk(input logic [7:0] ctrl, input logic [1:0] kind, input logic word, input logic io8,
		input logic [15:0] addr, input logic [15:0] data, input logic exp);
		wr(BAB_OFS_CTRL, {24'h0, ctrl});
		u_bab_cpu_model.cycle(kind, word, io8, addr, data);
		#1 chk({31'h0, irq}, {31'h0, exp}, "break request");
		rdchk(BAB_OFS_STAT, {24'h0, exp, 7'h7f}, "break flag");
		wr(BAB_OFS_STAT, 32'h40);
		#1 chk({31'h0, irq}, 32'h0, "flag cleared");
	endtask

	function automatic logic [7:0] cfg(input logic [1:0] d);
		cfg = {1'b1, 2'h3, 3'h1, d};
	endfunction

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic reset_values;
		logic [31:0] r;
		logic e;
		rdchk(BAB_OFS_CTRL, 32'h80, "control reset");
		rdchk(BAB_OFS_STAT, 32'h3f, "status reset");
		rdchk(BAB_OFS_ADDR, 32'hffff, "address reset");
		apb(1'b0, 12'h010, 32'h0, r, e);
		chk(r, 32'h0, "unmapped read");
		chk({31'h0, e}, 32'h1, "unmapped error");
		wr(BAB_OFS_ADDR, 32'h1234);
		rdchk(BAB_OFS_ADDR, 32'h1234, "address write");
		wr(BAB_OFS_STAT, 32'h40);
		rdchk(BAB_OFS_STAT, 32'h7f, "status write");
	endtask

	// Instruction address is the first byte
	task automatic cycle_types;
		for (int c = 0; c < 4; c++)
			for (int k = 0; k < 3; k++)
				brk({1'b1, 2'(c), 5'h0}, 2'(k), 1'b0, 1'b0, 16'h1234, 16'h0,
					(c == k) || (c == 3 && k != 0));
	endtask

	// Reserved compare widths never written
	task automatic addr_widths;
		for (int a = 0; a < 4; a++) begin
			brk({3'h5, 3'(a), 2'h0}, BAB_KIND_READ, 1'b0, 1'b0, 16'h1234 ^ (16'h1 << (4 * a)), 16'h0, 1'b0);
			if (a > 0)
				brk({3'h5, 3'(a), 2'h0}, BAB_KIND_READ, 1'b0, 1'b0, 16'h1234 ^ (16'h1 << (4 * a - 1)), 16'h0, 1'b1);
		end
	endtask

	// Byte value held in the high half, data written first
	task automatic data_lanes;
		wr(BAB_OFS_ADDR, 32'h2000);
		wr(BAB_OFS_DATA, 32'ha55a);
		brk(cfg(BAB_DCMP_HIGH), BAB_KIND_READ, 1'b0, 1'b0, 16'h2000, 16'ha500, 1'b1);
		brk(cfg(BAB_DCMP_HIGH), BAB_KIND_WRITE, 1'b0, 1'b0, 16'h2001, 16'ha5ff, 1'b1);
		brk(cfg(BAB_DCMP_HIGH), BAB_KIND_READ, 1'b0, 1'b0, 16'h2001, 16'h5aa5, 1'b0);
		brk(cfg(BAB_DCMP_WORD), BAB_KIND_READ, 1'b1, 1'b0, 16'h2000, 16'ha55a, 1'b1);
		brk(cfg(BAB_DCMP_WORD), BAB_KIND_READ, 1'b1, 1'b0, 16'h2000, 16'ha55b, 1'b0);
		brk(cfg(BAB_DCMP_LOW), BAB_KIND_WRITE, 1'b1, 1'b0, 16'h2001, 16'h005a, 1'b1);
		brk(cfg(BAB_DCMP_LOW), BAB_KIND_WRITE, 1'b1, 1'b0, 16'h2001, 16'h5a00, 1'b0);
		brk(cfg(BAB_DCMP_HIGH), BAB_KIND_READ, 1'b1, 1'b1, 16'h2001, 16'ha500, 1'b1);
		brk(cfg(BAB_DCMP_NONE), BAB_KIND_READ, 1'b0, 1'b0, 16'h2003, 16'h1111, 1'b1);
	endtask

	task automatic flag_clear;
		wr(BAB_OFS_STAT, 32'h0);
		u_bab_cpu_model.cycle(BAB_KIND_READ, 1'b0, 1'b0, 16'h2004, 16'h0);
		#1 chk({31'h0, irq}, 32'h0, "request while disabled");
		wr(BAB_OFS_STAT, 32'h40);
		#1 chk({31'h0, irq}, 32'h1, "zero write before read");
		rdchk(BAB_OFS_STAT, 32'hff, "flag and enable set");
		wr(BAB_OFS_STAT, 32'h40);
		#1 chk({31'h0, irq}, 32'h0, "zero write after read");
	endtask

	task automatic return_hold;
		wr(BAB_OFS_CTRL, 32'h0);
		u_bab_cpu_model.pulse(1'b0);
		#1 chk({31'h0, hold}, 32'h1, "hold after return");
		repeat (3) @(posedge clk);
		#1 chk({31'h0, hold}, 32'h1, "hold kept");
		u_bab_cpu_model.pulse(1'b1);
		@(posedge clk);
		#1 chk({31'h0, hold}, 32'h0, "hold ends");
		wr(BAB_OFS_CTRL, 32'h80);
		u_bab_cpu_model.pulse(1'b0);
		#1 chk({31'h0, hold}, 32'h0, "no hold when unmasked");
	endtask

	// Main sequence
	initial begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		reset_values;
		cycle_types;
		addr_widths;
		data_lanes;
		flag_clear;
		return_hold;
		results;
	end
endmodule
